// file: ext_bus_ctrl.sv
// Purpose: external bus sequencer with idle insertion and bus release
// Assumes: internal master holds its request fields stable until ACK
// Notes: read data on D_IN is sampled in the last cycle of a read

`timescale 1ns/1ps

//Contract
//- after reset the idle setting keeps read strobe and next chip select apart
//- primary count 1..4, alternate 0/2/3/4, per-area select picks alternate
//- during idle cycles the address already shows the next cycle's address
//- idle cycle: data floats, strobes and selects high, address hold low
//- release only in extended mode with release enable and pin input enable
//- sampled request drives grant low and floats address, data, control
//- while released all bus pins stay at high impedance
//- while released external accesses stall until the request is withdrawn
//- clock change written while released waits for request withdrawal
//- cancel output low on external access, standby sleep or clock write
//- release request beats a simultaneous internal external access
//- cancel output returns high with the rising edge of the grant
//- read after read in other area inserts selected idle cycles
//- write after read inserts selected idle cycles
//- read after write inserts primary count idle cycles only
//- cycles without external access count toward idle, shortfall inserted
module ext_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int AREAS = 8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // configuration
  input wire logic EXT_MODE,
  input wire logic BUS_RELEASE_ENABLE,
  input wire logic INPUT_BUFFER_CONTROL,
  input wire logic CANCEL_OUTPUT_ENABLE,
  input wire logic IDLE_WR,
  input wire logic [2:0] IDLE_CONDITION_BITS,
  input wire logic [AREAS-1:0] IDLE_COUNT_GROUP_SELECT,
  input wire logic [1:0] PRIMARY_IDLE_COUNT,
  input wire logic [1:0] ALTERNATE_IDLE_COUNT,
  // internal master request
  input wire logic REQ,
  input wire logic REQ_WRITE,
  input wire logic [$clog2(AREAS)-1:0] REQ_AREA,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [1:0] REQ_BYTE_EN,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic ACK,
  output logic [DATA_W-1:0] RDATA,
  // power and clock events
  input wire logic SLEEP_STANDBY_REQ,
  input wire logic CLK_CHANGE_WR,
  output logic CLK_CHANGE_APPLY,
  // release handshake pins
  input wire logic RELEASE_REQUEST_INPUT_N,
  output logic RELEASE_GRANT_N,
  output logic RELEASE_CANCEL_OUTPUT_N,
  // address and data pins
  output logic [ADDR_W-1:0] A_OUT,
  output logic A_OE,
  input wire logic [DATA_W-1:0] D_IN,
  output logic [DATA_W-1:0] D_OUT,
  output logic D_OE,
  // control pins, one shared enable
  output logic CTRL_OE,
  output logic [AREAS-1:0] CS_N,
  output logic ADDRESS_STROBE_N,
  output logic ADDRESS_HOLD,
  output logic BUS_START_N,
  output logic RD_N,
  output logic RD_WR,
  output logic UPPER_WRITE_STROBE_N,
  output logic LOWER_WRITE_STROBE_N,
  output logic UPPER_BYTE_SELECT_N,
  output logic LOWER_BYTE_SELECT_N
);

  // area index must cover every select bit exactly and fit the 8-bit reset value
  if (ADDR_W < 1 || DATA_W != 16 || AREAS < 2 || AREAS > 8 ||
      (AREAS & (AREAS - 1)) != 0) begin : g_chk
    $error("ext_bus_ctrl: unsupported width or area count");
  end

  // ----------------------------------------
  // idle control register
  // ----------------------------------------
  logic [2:0] cond_q, cond_d;
  logic [AREAS-1:0] sel_q, sel_d;
  logic [1:0] cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d;

  always_comb begin
    cond_d = cond_q;
    sel_d = sel_q;
    cnt_a_d = cnt_a_q;
    cnt_b_d = cnt_b_q;
    if (IDLE_WR) begin
      cond_d = IDLE_CONDITION_BITS;
      sel_d = IDLE_COUNT_GROUP_SELECT;
      cnt_a_d = PRIMARY_IDLE_COUNT;
      cnt_b_d = ALTERNATE_IDLE_COUNT;
    end
  end

  // defaults give one idle cycle so read strobe never meets the next select
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cond_q <= IDLE_COND_RST;
      sel_q <= IDLE_SEL_RST[AREAS-1:0];
      cnt_a_q <= IDLE_A_RST;
      cnt_b_q <= IDLE_B_RST;
    end else begin
      cond_q <= cond_d;
      sel_q <= sel_d;
      cnt_a_q <= cnt_a_d;
      cnt_b_q <= cnt_b_d;
    end
  end

  // ----------------------------------------
  // release request synchroniser
  // ----------------------------------------
  logic release_request_input_n;

  pin_sync #(.RST_VAL(1'b1)) u_release_request_input_sync (
    .clk(REF_CLK),
    .rst(RST),
    .pin(RELEASE_REQUEST_INPUT_N),
    .level(release_request_input_n)
  );

  logic rel_ok;
  assign rel_ok = EXT_MODE && BUS_RELEASE_ENABLE && INPUT_BUFFER_CONTROL;

  // ----------------------------------------
  // sequencer and pin drive
  // ----------------------------------------
  bus_state_e st_q, st_d;
  logic last_v_q, last_v_d, last_rd_q, last_rd_d;
  logic [$clog2(AREAS)-1:0] last_area_q, last_area_d;
  logic [2:0] nop_q, nop_d, gap_q, gap_d, need;
  logic clk_pend_q, clk_pend_d, apply_q, apply_d;
  logic ack_q, ack_d, back_q, back_d, release_cancel_output_q, release_cancel_output_d;
  logic [DATA_W-1:0] rdata_q, rdata_d, dout_q, dout_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic aoe_q, aoe_d, doe_q, doe_d, coe_q, coe_d;
  logic [AREAS-1:0] cs_q, cs_d;
  logic as_q, as_d, ah_q, ah_d, bs_q, bs_d, rd_q, rd_d, rdwr_q, rdwr_d;
  logic uw_q, uw_d, lw_q, lw_d, ub_q, ub_d, lb_q, lb_d;
  logic [2:0] req_cyc;

  // required idle cycles for the pending access against the last external one
  always_comb begin
    req_cyc = ZERO_CYC;
    if (last_v_q && last_rd_q && !REQ_WRITE && cond_q[COND_RAR] &&
        REQ_AREA != last_area_q) begin
      req_cyc = idle_count(sel_q[REQ_AREA] ? cnt_b_q : cnt_a_q, sel_q[REQ_AREA]);
    end
    if (last_v_q && last_rd_q && REQ_WRITE && cond_q[COND_WAR]) begin
      req_cyc = idle_count(sel_q[REQ_AREA] ? cnt_b_q : cnt_a_q, sel_q[REQ_AREA]);
    end
    if (last_v_q && !last_rd_q && !REQ_WRITE && cond_q[COND_RAW]) begin
      req_cyc = idle_count(cnt_a_q, 1'b0);
    end
    need = (req_cyc > nop_q) ? req_cyc - nop_q : ZERO_CYC;
  end

  always_comb begin
    st_d = st_q;
    gap_d = gap_q;
    nop_d = nop_q;
    last_v_d = last_v_q;
    last_rd_d = last_rd_q;
    last_area_d = last_area_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    case (st_q)
      S_IDLE: begin
        if (rel_ok && !release_request_input_n) begin
          st_d = S_REL;
        end else if (REQ && need != ZERO_CYC) begin
          st_d = S_GAP;
          gap_d = need;
        end else if (REQ) begin
          st_d = S_T1;
        end else if (nop_q != NOP_MAX) begin
          nop_d = nop_q + ONE_CYC;
        end
      end
      S_GAP: begin
        gap_d = gap_q - ONE_CYC;
        if (gap_q == ONE_CYC) begin
          st_d = S_T1;
        end
      end
      S_T1: st_d = S_T2;
      S_T2: begin
        st_d = S_IDLE;
        ack_d = 1'b1;
        nop_d = ZERO_CYC;
        last_v_d = 1'b1;
        last_rd_d = !REQ_WRITE;
        last_area_d = REQ_AREA;
        if (!REQ_WRITE) begin
          rdata_d = D_IN;
        end
      end
      S_REL: begin
        // external access waits here; the withdrawal returns the bus
        if (release_request_input_n) begin
          st_d = S_IDLE;
        end else if (nop_q != NOP_MAX) begin
          nop_d = nop_q + ONE_CYC;
        end
      end
      default: st_d = S_IDLE;
    endcase

    // pin values follow the next state so they line up with st_q
    a_d = a_q;
    aoe_d = 1'b1;
    coe_d = 1'b1;
    doe_d = 1'b0;
    dout_d = dout_q;
    cs_d = '1;
    as_d = 1'b1;
    ah_d = 1'b0;
    bs_d = 1'b1;
    rd_d = 1'b1;
    rdwr_d = 1'b1;
    uw_d = 1'b1;
    lw_d = 1'b1;
    ub_d = 1'b1;
    lb_d = 1'b1;
    back_d = 1'b1;
    case (st_d)
      S_GAP: a_d = REQ_ADDR;
      S_T1, S_T2: begin
        a_d = REQ_ADDR;
        cs_d[REQ_AREA] = 1'b0;
        as_d = 1'b0;
        bs_d = (st_d != S_T1);
        rd_d = REQ_WRITE;
        rdwr_d = !REQ_WRITE;
        ub_d = !REQ_BYTE_EN[1];
        lb_d = !REQ_BYTE_EN[0];
        uw_d = !(REQ_WRITE && REQ_BYTE_EN[1]);
        lw_d = !(REQ_WRITE && REQ_BYTE_EN[0]);
        doe_d = REQ_WRITE;
        dout_d = REQ_WDATA;
      end
      S_REL: begin
        back_d = 1'b0;
        aoe_d = 1'b0;
        coe_d = 1'b0;
      end
      default: ;
    endcase

    // clock change waits while the bus is out
    clk_pend_d = clk_pend_q;
    apply_d = 1'b0;
    if (st_d == S_REL) begin
      clk_pend_d = clk_pend_q || CLK_CHANGE_WR;
    end else if (clk_pend_q || CLK_CHANGE_WR) begin
      apply_d = 1'b1;
      clk_pend_d = 1'b0;
    end

    // cancel output only while released; it lifts as the grant lifts
    release_cancel_output_d = !(CANCEL_OUTPUT_ENABLE && st_d == S_REL &&
                (REQ || SLEEP_STANDBY_REQ || clk_pend_q || CLK_CHANGE_WR));
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= S_IDLE;
      gap_q <= ZERO_CYC;
      nop_q <= NOP_MAX;
      last_v_q <= 1'b0;
      last_rd_q <= 1'b0;
      last_area_q <= '0;
      ack_q <= 1'b0;
      rdata_q <= '0;
      clk_pend_q <= 1'b0;
      apply_q <= 1'b0;
      release_cancel_output_q <= 1'b1;
      back_q <= 1'b1;
      a_q <= '0;
      aoe_q <= 1'b1;
      coe_q <= 1'b1;
      doe_q <= 1'b0;
      dout_q <= '0;
      cs_q <= '1;
      as_q <= 1'b1;
      ah_q <= 1'b0;
      bs_q <= 1'b1;
      rd_q <= 1'b1;
      rdwr_q <= 1'b1;
      uw_q <= 1'b1;
      lw_q <= 1'b1;
      ub_q <= 1'b1;
      lb_q <= 1'b1;
    end else begin
      st_q <= st_d;
      gap_q <= gap_d;
      nop_q <= nop_d;
      last_v_q <= last_v_d;
      last_rd_q <= last_rd_d;
      last_area_q <= last_area_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      clk_pend_q <= clk_pend_d;
      apply_q <= apply_d;
      release_cancel_output_q <= release_cancel_output_d;
      back_q <= back_d;
      a_q <= a_d;
      aoe_q <= aoe_d;
      coe_q <= coe_d;
      doe_q <= doe_d;
      dout_q <= dout_d;
      cs_q <= cs_d;
      as_q <= as_d;
      ah_q <= ah_d;
      bs_q <= bs_d;
      rd_q <= rd_d;
      rdwr_q <= rdwr_d;
      uw_q <= uw_d;
      lw_q <= lw_d;
      ub_q <= ub_d;
      lb_q <= lb_d;
    end
  end

  assign ACK = ack_q;
  assign RDATA = rdata_q;
  assign CLK_CHANGE_APPLY = apply_q;
  assign RELEASE_GRANT_N = back_q;
  assign RELEASE_CANCEL_OUTPUT_N = release_cancel_output_q;
  assign A_OUT = a_q;
  assign A_OE = aoe_q;
  assign D_OUT = dout_q;
  assign D_OE = doe_q;
  assign CTRL_OE = coe_q;
  assign CS_N = cs_q;
  assign ADDRESS_STROBE_N = as_q;
  assign ADDRESS_HOLD = ah_q;
  assign BUS_START_N = bs_q;
  assign RD_N = rd_q;
  assign RD_WR = rdwr_q;
  assign UPPER_WRITE_STROBE_N = uw_q;
  assign LOWER_WRITE_STROBE_N = lw_q;
  assign UPPER_BYTE_SELECT_N = ub_q;
  assign LOWER_BYTE_SELECT_N = lb_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  AST_GAP_PINS: assert property ((st_q == S_GAP) |-> (CS_N == '1 && ADDRESS_STROBE_N &&
    RD_N && BUS_START_N && RD_WR && !ADDRESS_HOLD && !D_OE && UPPER_WRITE_STROBE_N &&
    LOWER_WRITE_STROBE_N)) else $error("idle cycle pin state wrong");
  AST_GAP_ADDR: assert property ((st_q == S_GAP) |-> (A_OUT == REQ_ADDR && A_OE))
    else $error("idle cycle address not next address");
  AST_REL_FLOAT: assert property ((!RELEASE_GRANT_N) |-> (!A_OE && !D_OE && !CTRL_OE))
    else $error("bus driven while released");
  AST_REL_ENTRY: assert property ((st_q == S_IDLE && !release_request_input_n && !rel_ok) |=> st_q != S_REL)
    else $error("released without enables");
  AST_REL_PRIO: assert property ((st_q == S_IDLE && rel_ok && !release_request_input_n && REQ)
    |=> (st_q == S_REL && !RELEASE_GRANT_N)) else $error("access beat release request");
  AST_BOUNDARY: assert property ($rose(st_q == S_REL) |-> $past(st_q) == S_IDLE)
    else $error("grant mid cycle");
  AST_CANCEL_RISE: assert property ($rose(RELEASE_GRANT_N) |-> RELEASE_CANCEL_OUTPUT_N)
    else $error("cancel output low after grant rose");
  AST_CLK_DEFER: assert property ((st_q == S_REL) |-> !CLK_CHANGE_APPLY)
    else $error("clock applied while out");
  AST_STALL: assert property ((st_q == S_REL && REQ && !release_request_input_n) |=> !ACK)
    else $error("external access while released");
  AST_GAP_LEN: assert property ((st_q == S_IDLE && REQ && !(rel_ok && !release_request_input_n) &&
    need == 3'h2) |=> (st_q == S_GAP)[*2] ##1 (st_q == S_T1)) else $error("gap length wrong");

endmodule : ext_bus_ctrl

// file: ext_bus_master_model.sv
// Purpose: outside master that borrows the external bus
// Assumes: grant sampled on the rising bus clock edge
// Notes: keeps its request low for hold_cycles after grant; no abort of its own

`timescale 1ns/1ps

module ext_bus_master_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic start,
  input wire logic [7:0] hold_cycles,
  // release handshake
  input wire logic grant_n,
  output logic req_n,
  output logic owns
);
  logic [7:0] cnt;

  initial begin
    req_n = 1'b1;
    owns = 1'b0;
    cnt = 8'h00;
  end

  always @(posedge clk) begin
    if (rst) begin
      req_n <= 1'b1;
      owns <= 1'b0;
    end else if (start && req_n) begin
      req_n <= 1'b0;
      cnt <= hold_cycles;
    end else if (!req_n && !grant_n) begin
      owns <= 1'b1;
      if (cnt == 8'h00) begin
        // float together with the withdrawal so the device never meets us driving
        owns <= 1'b0;
        req_n <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : ext_bus_master_model

// file: ext_bus_pkg.sv
// Purpose: shared constants for the external bus idle and release logic
// Assumes: one clock, synchronous active-high reset
// Notes: idle counts are in bus clock cycles

package ext_bus_pkg;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_GAP  = 5'h02,
    S_T1   = 5'h04,
    S_T2   = 5'h08,
    S_REL  = 5'h10
  } bus_state_e;

  // ----------------------------------------
  // idle condition bit positions and reset values
  // ----------------------------------------
  localparam int COND_WAR = 0;
  localparam int COND_RAR = 1;
  localparam int COND_RAW = 2;
  localparam logic [2:0] IDLE_COND_RST = 3'h7;
  localparam logic [7:0] IDLE_SEL_RST = 8'h00;
  localparam logic [1:0] IDLE_A_RST = 2'h0;
  localparam logic [1:0] IDLE_B_RST = 2'h0;

  // ----------------------------------------
  // counts
  // ----------------------------------------
  localparam logic [2:0] NOP_MAX = 3'h4;
  localparam logic [2:0] ONE_CYC = 3'h1;
  localparam logic [2:0] ZERO_CYC = 3'h0;

  // primary field maps 0..3 to 1..4, alternate maps 0 to 0 and 1..3 to 2..4
  function automatic logic [2:0] idle_count(input logic [1:0] code, input logic alt);
    logic [2:0] n;
    n = {1'b0, code} + ONE_CYC;
    if (alt && code == 2'h0) begin
      n = ZERO_CYC;
    end
    return n;
  endfunction : idle_count

endpackage : ext_bus_pkg

// file: external_bus_idle_and_release_test.sv
// Purpose: self-checking bench for idle insertion and bus release
// Assumes: read data is bus-synchronous and follows the address
// Notes: gap lengths predicted from the idle settings the bench loaded

`timescale 1ns/1ps

module external_bus_idle_and_release_test;
  import ext_bus_pkg::*;
  // ----------------
  // signals
  // ----------------
  logic REF_CLK, RST, EXT_MODE, BUS_RELEASE_ENABLE, INPUT_BUFFER_CONTROL;
  logic CANCEL_OUTPUT_ENABLE, IDLE_WR, REQ, REQ_WRITE, ACK, SLEEP_STANDBY_REQ;
  logic CLK_CHANGE_WR, CLK_CHANGE_APPLY, RELEASE_REQUEST_INPUT_N, RELEASE_GRANT_N;
  logic RELEASE_CANCEL_OUTPUT_N, A_OE, D_OE, CTRL_OE, ADDRESS_STROBE_N, ADDRESS_HOLD;
  logic BUS_START_N, RD_N, RD_WR, UPPER_WRITE_STROBE_N, LOWER_WRITE_STROBE_N;
  logic UPPER_BYTE_SELECT_N, LOWER_BYTE_SELECT_N;
  logic [2:0] IDLE_CONDITION_BITS, REQ_AREA, prev_ar;
  logic [7:0] IDLE_COUNT_GROUP_SELECT, CS_N, m_hold;
  logic [1:0] PRIMARY_IDLE_COUNT, ALTERNATE_IDLE_COUNT, REQ_BYTE_EN;
  logic [23:0] REQ_ADDR, A_OUT;
  logic [15:0] REQ_WDATA, RDATA, D_IN, D_OUT;
  logic m_start, m_rst, m_owns, have_prev, prev_w;
  int err_total, num_checks, nops;

  function automatic logic [15:0] mem(input logic [23:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5a5a;
  endfunction : mem

  // the outside master puts its own pattern on the data wires while it owns them
  assign D_IN = D_OE ? D_OUT : (m_owns ? 16'hc3c3 : mem(A_OUT));

  ext_bus_ctrl ext_bus_ctrl_inst (.REF_CLK, .RST, .EXT_MODE, .BUS_RELEASE_ENABLE,
    .INPUT_BUFFER_CONTROL, .CANCEL_OUTPUT_ENABLE, .IDLE_WR, .IDLE_CONDITION_BITS,
    .IDLE_COUNT_GROUP_SELECT, .PRIMARY_IDLE_COUNT, .ALTERNATE_IDLE_COUNT, .REQ, .REQ_WRITE,
    .REQ_AREA, .REQ_ADDR, .REQ_BYTE_EN, .REQ_WDATA, .ACK, .RDATA, .SLEEP_STANDBY_REQ,
    .CLK_CHANGE_WR, .CLK_CHANGE_APPLY, .RELEASE_REQUEST_INPUT_N, .RELEASE_GRANT_N,
    .RELEASE_CANCEL_OUTPUT_N, .A_OUT, .A_OE, .D_IN, .D_OUT, .D_OE, .CTRL_OE, .CS_N,
    .ADDRESS_STROBE_N, .ADDRESS_HOLD, .BUS_START_N, .RD_N, .RD_WR, .UPPER_WRITE_STROBE_N,
    .LOWER_WRITE_STROBE_N, .UPPER_BYTE_SELECT_N, .LOWER_BYTE_SELECT_N);

  ext_bus_master_model ext_bus_master_model_inst (.clk(REF_CLK), .rst(m_rst),
    .start(m_start), .hold_cycles(m_hold), .grant_n(RELEASE_GRANT_N),
    .req_n(RELEASE_REQUEST_INPUT_N), .owns(m_owns));

  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  // ----------------
  // helpers
  // ----------------
  task automatic tick();
    @(posedge REF_CLK);
    #1;
  endtask : tick

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task automatic bound(input string nm, input int k, input int lim);
    if (k >= lim) begin
      chk(nm, 0, 1);
      print_verdict();
    end
  endtask : bound

  function automatic int exp_gap(input logic w, input logic [2:0] ar, input int idle);
    logic alt;
    logic [1:0] code;
    int n;
    alt = IDLE_COUNT_GROUP_SELECT[ar];
    n = 0;
    if (have_prev && !prev_w && !w && ar != prev_ar && IDLE_CONDITION_BITS[1]) n = 1;
    if (have_prev && !prev_w && w && IDLE_CONDITION_BITS[0]) n = 1;
    if (have_prev && prev_w && !w && IDLE_CONDITION_BITS[2]) begin
      n = 1;
      alt = 1'b0;
    end
    code = alt ? ALTERNATE_IDLE_COUNT : PRIMARY_IDLE_COUNT;
    if (n == 1) n = (alt && code == 2'h0) ? 0 : code + 1;
    return (n > idle) ? n - idle : 0;
  endfunction : exp_gap

  task automatic set_cfg();
    REQ = 1'b0;
    IDLE_CONDITION_BITS = $urandom;
    IDLE_COUNT_GROUP_SELECT = $urandom;
    PRIMARY_IDLE_COUNT = $urandom;
    ALTERNATE_IDLE_COUNT = $urandom;
    IDLE_WR = 1'b1;
    tick();
    IDLE_WR = 1'b0;
    nops++;
  endtask : set_cfg

  // ----------------
  // one external access, d quiet cycles before it
  // ----------------
  task automatic access(input logic w, input logic [2:0] ar, input int d);
    int k, g;
    logic [23:0] ad;
    logic [15:0] wd;
    ad = $urandom;
    wd = $urandom;
    if (d > 0) REQ = 1'b0;
    repeat (d) tick();
    g = exp_gap(w, ar, nops + d);
    REQ = 1'b1;
    REQ_WRITE = w;
    REQ_AREA = ar;
    REQ_ADDR = ad;
    REQ_WDATA = wd;
    REQ_BYTE_EN = 2'($urandom_range(3, 1));
    k = 0;
    tick();
    while (CS_N === 8'hff && k < 8) begin
      chk("gap_addr", ad, A_OUT);
      chk("gap_pins", 9'h0fd, {D_OE, ADDRESS_STROBE_N, RD_N, BUS_START_N, RD_WR,
        UPPER_WRITE_STROBE_N, LOWER_WRITE_STROBE_N, ADDRESS_HOLD, CTRL_OE});
      k++;
      tick();
    end
    chk("gap_len", g, k);
    chk("cs_n", 8'h01 << ar, CS_N ^ 8'hff);
    chk("rd_wr", !w, RD_WR);
    tick();
    if (w) chk("wdata", {1'b1, wd}, {D_OE, D_OUT});
    k = 0;
    while (ACK !== 1'b1 && k < 8) begin
      k++;
      tick();
    end
    bound("ack", k, 8);
    if (!w) chk("rdata", mem(ad), RDATA);
    have_prev = 1'b1;
    prev_w = w;
    prev_ar = ar;
    nops = 0;
  endtask : access

  // ----------------
  // release with one cancel cause: 0 access, 1 sleep, 2 clock write
  // ----------------
  task automatic release_case(input int cause, input logic [7:0] h);
    int k;
    REQ = 1'b0;
    CANCEL_OUTPUT_ENABLE = $urandom;
    m_hold = h;
    m_start = 1'b1;
    tick();
    m_start = 1'b0;
    // the access arrives in the same cycle as the synchronised request
    repeat (4) tick();
    REQ = (cause == 0);
    REQ_WRITE = 1'b0;
    REQ_AREA = 3'h2;
    REQ_ADDR = 24'h00a5c3;
    k = 0;
    while (RELEASE_GRANT_N !== 1'b0 && k < 8) begin
      k++;
      tick();
    end
    bound("grant", k, 8);
    chk("grant_oe", 3'h0, {A_OE, D_OE, CTRL_OE});
    SLEEP_STANDBY_REQ = (cause == 1);
    CLK_CHANGE_WR = (cause == 2);
    tick();
    CLK_CHANGE_WR = 1'b0;
    k = 0;
    while (RELEASE_GRANT_N === 1'b0 && k < 300) begin
      chk("released", 5'h00, {ACK, CLK_CHANGE_APPLY, A_OE, D_OE, CTRL_OE});
      if (k > 1) chk("cancel", !CANCEL_OUTPUT_ENABLE, RELEASE_CANCEL_OUTPUT_N);
      k++;
      tick();
    end
    bound("withdraw", k, 300);
    chk("back", {3'h7, cause == 2}, {RELEASE_CANCEL_OUTPUT_N, A_OE, CTRL_OE,
      CLK_CHANGE_APPLY});
    SLEEP_STANDBY_REQ = 1'b0;
    nops = 4;
    if (cause == 0) begin
      k = 0;
      while (ACK !== 1'b1 && k < 10) begin
        k++;
        tick();
      end
      bound("late_ack", k, 10);
      chk("rel_rdata", mem(24'h00a5c3), RDATA);
      REQ = 1'b0;
      prev_w = 1'b0;
      prev_ar = 3'h2;
      nops = 0;
    end
  endtask : release_case

  // ----------------
  // main sequence
  // ----------------
  initial begin
    RST = 1'b1;
    m_rst = 1'b1;
    {EXT_MODE, BUS_RELEASE_ENABLE, INPUT_BUFFER_CONTROL, CANCEL_OUTPUT_ENABLE} = 4'hf;
    {IDLE_WR, REQ, REQ_WRITE, SLEEP_STANDBY_REQ, CLK_CHANGE_WR, m_start} = 6'h00;
    IDLE_CONDITION_BITS = 3'h7;
    IDLE_COUNT_GROUP_SELECT = 8'h00;
    PRIMARY_IDLE_COUNT = 2'h0;
    ALTERNATE_IDLE_COUNT = 2'h0;
    REQ_AREA = 3'h0;
    REQ_ADDR = 24'h000000;
    REQ_BYTE_EN = 2'h3;
    REQ_WDATA = 16'h0000;
    m_hold = 8'h00;
    {have_prev, prev_w, prev_ar} = 5'h00;
    err_total = 0;
    num_checks = 0;
    nops = 4;
    void'($urandom(68));
    repeat (2) tick();
    RST = 1'b0;
    m_rst = 1'b0;
    chk("reset", 6'h3c, {RELEASE_GRANT_N, RELEASE_CANCEL_OUTPUT_N, A_OE, CTRL_OE, D_OE, ACK});
    access(1'b0, 3'h0, 0);
    access(1'b0, 3'h1, 0);
    access(1'b1, 3'h1, 0);
    access(1'b0, 3'h1, 0);
    access(1'b0, 3'h1, 0);
    access(1'b0, 3'h2, 1);
    for (int c = 0; c < 3; c++) begin
      release_case(c, 8'(6 + c));
    end
    for (int i = 0; i < 3; i++) begin
      {EXT_MODE, BUS_RELEASE_ENABLE, INPUT_BUFFER_CONTROL} = ~(3'h1 << i);
      m_start = 1'b1;
      tick();
      m_start = 1'b0;
      repeat (8) begin
        chk("no_grant", 2'h3, {RELEASE_GRANT_N, A_OE});
        tick();
      end
      m_rst = 1'b1;
      tick();
      m_rst = 1'b0;
    end
    // let the synchronised request settle high before release is allowed again
    repeat (4) tick();
    {EXT_MODE, BUS_RELEASE_ENABLE, INPUT_BUFFER_CONTROL} = 3'h7;
    repeat (6) begin
      set_cfg();
      repeat (30) begin
        access(1'($urandom), 3'($urandom), ($urandom % 3 == 0) ? $urandom_range(4, 1) : 0);
      end
    end
    REQ = 1'b0;
    tick();
    print_verdict();
  end
endmodule : external_bus_idle_and_release_test

// file: pin_sync.sv
// Purpose: three-stage synchroniser for an asynchronous pin
// Assumes: pin may change at any time relative to clk
// Notes: output moves only when stages two and three agree

`timescale 1ns/1ps

module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic pin,
  output logic level
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule : pin_sync
